// [verilog/clg_logic_element.sv]
// configurable logic element with delays, counter, latch and edge pulse
//
// Behaviour
// - inverted option complements the element output
// - output rises after condition held on-delay
// - output stays active for off-delay afterwards
// - counter gate compares count with setting
// - counter gate has count and reset inputs
// - reverse swaps AND and OR stages
// - AND group and OR group sized separately
// - inverted-input gates complement extra inputs
// - latch has set, data, load, reset inputs
// - latch reset dominates, forcing output zero
// - set latch holds one until reset
//
// The address map and the Wishbone slave port were decided locally.
`include "clg_defines.svh"

module clg_logic_element #(
	parameter int MS_CYCLES = `CLG_MS_CYCLES,
	parameter int PULSE_CYCLES = `CLG_PULSE_MS * `CLG_MS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input clg_pkg::clg_wb_req_t wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] sig_i,
	output logic sig_o
);
	import clg_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// low n bits set, n clipped to the eight lanes of a group
	function automatic logic [7:0] clg_mask(input logic [3:0] n);
		clg_mask = (n >= 4'h8) ? 8'hff : 8'((9'h001 << n) - 9'h001);
	endfunction
	// and of the used inputs; an empty group never asserts
	function automatic logic clg_all(input logic [7:0] g,
		input logic [3:0] n);
		clg_all = (n != 4'h0) && (&(g | ~clg_mask(n)));
	endfunction
	function automatic logic clg_any(input logic [7:0] g,
		input logic [3:0] n);
		clg_any = |(g & clg_mask(n));
	endfunction
	function automatic logic [15:0] clg_wr16(input logic [15:0] old,
		input logic [15:0] d, input logic [1:0] sel);
		clg_wr16 = {sel[1] ? d[15:8] : old[15:8],
			sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// ****************************************
	// state
	// ****************************************
	clg_ctrl_t ctrl_reg;
	logic [15:0] counts_reg, on_ms_reg, off_ms_reg, setting_reg;
	logic [31:0] rdat_reg, rd_next;
	logic [17:0] pre_reg;
	logic [15:0] tmr_reg, cnt_reg, target;
	logic [22:0] pls_reg;
	logic ack_reg, dly_reg, cin_prev_reg, latch_reg;
	logic src_prev_reg, pulse_reg, out_reg;
	logic cond, req, tick, cin, crst, src, hit;
	logic set_any, data_any, load_any, lrst_any;
	logic [7:0] grp_a, grp_b;
	logic [3:0] na, nb;

	// group a carries normal, AND, count and edge inputs; group b the rest
	assign grp_a = sig_i[7:0];
	assign grp_b = sig_i[15:8];
	assign na = counts_reg[`CLG_CNT_A_LSB +: 4];
	assign nb = counts_reg[`CLG_CNT_B_LSB +: 4];

	// ****************************************
	// wishbone slave
	// ****************************************
	// one wait state: ack rises the cycle after the request, drops after
	assign req = wb_i.cyc && wb_i.stb && !ack_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	// writes act when the request is first seen; unmapped writes vanish
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= clg_ctrl_t'(`CLG_RST_CTRL);
			counts_reg <= `CLG_RST_COUNTS;
			on_ms_reg <= `CLG_RST_ON_MS;
			off_ms_reg <= `CLG_RST_OFF_MS;
			setting_reg <= `CLG_RST_SETTING;
		end else if (req && wb_i.we) begin
			unique case (wb_i.adr)
				`CLG_ADR_CTRL: begin
					if (wb_i.sel[0]) begin
						ctrl_reg <= clg_ctrl_t'(wb_i.dat[7:0]);
					end
				end
				`CLG_ADR_COUNTS: counts_reg <= clg_wr16(counts_reg,
					wb_i.dat[15:0], wb_i.sel[1:0]);
				`CLG_ADR_ON_MS: on_ms_reg <= clg_wr16(on_ms_reg,
					wb_i.dat[15:0], wb_i.sel[1:0]);
				`CLG_ADR_OFF_MS: off_ms_reg <= clg_wr16(off_ms_reg,
					wb_i.dat[15:0], wb_i.sel[1:0]);
				`CLG_ADR_SETTING: setting_reg <= clg_wr16(setting_reg,
					wb_i.dat[15:0], wb_i.sel[1:0]);
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		unique case (wb_i.adr)
			`CLG_ADR_CTRL: rd_next[7:0] = ctrl_reg;
			`CLG_ADR_COUNTS: rd_next[15:0] = counts_reg;
			`CLG_ADR_ON_MS: rd_next[15:0] = on_ms_reg;
			`CLG_ADR_OFF_MS: rd_next[15:0] = off_ms_reg;
			`CLG_ADR_SETTING: rd_next[15:0] = setting_reg;
			`CLG_ADR_STATUS: begin
				rd_next[`CLG_ST_OUT] = out_reg;
				rd_next[`CLG_ST_COND] = cond;
				rd_next[`CLG_ST_LATCH] = latch_reg;
				rd_next[`CLG_ST_PULSE] = pulse_reg;
				rd_next[`CLG_ST_DLY] = dly_reg;
				rd_next[`CLG_ST_CNT_LSB +: 16] = cnt_reg;
			end
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_reg <= 32'h0000_0000;
		end else if (req) begin
			rdat_reg <= rd_next;
		end
	end

	// ****************************************
	// logical condition
	// ****************************************
	always_comb begin
		unique case (ctrl_reg.gate)
			CLG_AND: cond = clg_all(grp_a, na);
			CLG_OR: cond = clg_any(grp_a, na);
			CLG_XOR: cond = ^(grp_a & clg_mask(na));
			CLG_INV_IN_AND: cond = ((na | nb) != 4'h0)
				&& (&(grp_a | ~clg_mask(na)))
				&& (&(~grp_b | ~clg_mask(nb)));
			CLG_INV_IN_OR: cond = clg_any(grp_a, na)
				|| clg_any(~grp_b, nb);
			// reverse feeds the OR stage into the AND stage
			CLG_AND_OR: cond = ctrl_reg.reverse
				? (clg_any(grp_a, na) && clg_all(grp_b, nb))
				: (clg_all(grp_a, na) || clg_any(grp_b, nb));
			CLG_COUNTER: cond = (cnt_reg >= setting_reg);
			CLG_LATCH: cond = latch_reg;
			CLG_EDGE: cond = 1'b0;
			default: cond = 1'b0;
		endcase
	end

	// ****************************************
	// on and off delays
	// ****************************************
	// the prescaler restarts whenever no delay runs, so a delay of n ms
	// is n whole milliseconds and never shorter
	assign tick = (pre_reg == 18'(MS_CYCLES - 1));
	assign target = dly_reg ? off_ms_reg : on_ms_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_reg <= 18'h0_0000;
		end else if (cond == dly_reg || tick) begin
			pre_reg <= 18'h0_0000;
		end else begin
			pre_reg <= pre_reg + 18'h0_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dly_reg <= 1'b0;
			tmr_reg <= 16'h0000;
		end else if (cond == dly_reg) begin
			tmr_reg <= 16'h0000;
		end else if (tmr_reg >= target) begin
			dly_reg <= cond;
			tmr_reg <= 16'h0000;
		end else if (tick) begin
			tmr_reg <= tmr_reg + 16'h0001;
		end
	end

	// ****************************************
	// counter gate
	// ****************************************
	assign cin = clg_any(grp_a, na);
	assign crst = clg_any(grp_b, nb);

	// counts rising edges of the count group, saturating at the top
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 16'h0000;
			cin_prev_reg <= 1'b0;
		end else begin
			cin_prev_reg <= cin;
			if (crst) begin
				cnt_reg <= 16'h0000;
			end else if (cin && !cin_prev_reg && cnt_reg != 16'hffff) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

	// ****************************************
	// set/reset/data/load latch
	// ****************************************
	assign set_any = clg_any({4'h0, sig_i[3:0]},
		counts_reg[`CLG_CNT_A_LSB +: 4]);
	assign data_any = clg_any({4'h0, sig_i[7:4]},
		counts_reg[`CLG_CNT_B_LSB +: 4]);
	assign load_any = clg_any({4'h0, sig_i[11:8]},
		counts_reg[`CLG_CNT_C_LSB +: 4]);
	assign lrst_any = clg_any({4'h0, sig_i[15:12]},
		counts_reg[`CLG_CNT_D_LSB +: 4]);

	// load with data low leaves the state alone, so a set latch holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_reg <= 1'b0;
		end else if (lrst_any) begin
			latch_reg <= 1'b0;
		end else if (set_any || (load_any && data_any)) begin
			latch_reg <= 1'b1;
		end
	end

	// ****************************************
	// edge pulse
	// ****************************************
	assign src = clg_any(grp_a, na);
	assign hit = ctrl_reg.edge_fall ? (src_prev_reg && !src)
		: (!src_prev_reg && src);

	// edges during a running pulse are ignored, never retriggered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_prev_reg <= 1'b0;
			pulse_reg <= 1'b0;
			pls_reg <= 23'h00_0000;
		end else begin
			src_prev_reg <= src;
			if (pulse_reg) begin
				pls_reg <= pls_reg + 23'h00_0001;
				if (pls_reg == 23'(PULSE_CYCLES - 1)) begin
					pulse_reg <= 1'b0;
				end
			end else if (hit && ctrl_reg.gate == CLG_EDGE) begin
				pulse_reg <= 1'b1;
				pls_reg <= 23'h00_0000;
			end
		end
	end

	// ****************************************
	// output
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_reg <= 1'b0;
		end else if (ctrl_reg.gate == CLG_EDGE) begin
			out_reg <= (pulse_reg ^ ctrl_reg.neg_pulse)
				^ ctrl_reg.invert;
		end else begin
			out_reg <= dly_reg ^ ctrl_reg.invert;
		end
	end

	assign sig_o = out_reg;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// ****************************************
	// assertions
	// ****************************************
	a_invert_out: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(dly_reg) && ctrl_reg.gate != CLG_EDGE && $stable(ctrl_reg)
		|=> sig_o == !ctrl_reg.invert)
		else $error("output polarity ignores the invert option");
	a_on_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		cond && !dly_reg && on_ms_reg == 16'h0000 |=> dly_reg)
		else $error("zero on delay did not assert at once");
	a_on_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		!dly_reg && tmr_reg < on_ms_reg |=> !dly_reg)
		else $error("output rose before the on delay ran out");
	a_off_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		dly_reg && tmr_reg < off_ms_reg |=> dly_reg)
		else $error("output fell before the off delay ran out");
	a_count_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_reg.gate == CLG_COUNTER && cnt_reg < setting_reg |-> !cond)
		else $error("counter gate true below its setting");
	a_count_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		crst |=> cnt_reg == 16'h0000)
		else $error("counter reset input did not clear the count");
	a_andor_rev: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_reg.gate == CLG_AND_OR && ctrl_reg.reverse
		&& !clg_any(grp_a, na) |-> !cond)
		else $error("reversed gate true with its OR stage low");
	a_inv_input: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_reg.gate == CLG_INV_IN_AND && |(grp_b & clg_mask(nb))
		|-> !cond)
		else $error("inverted input high yet gate asserted");
	a_reset_dom: assert property (@(posedge clk_i) disable iff (rst_i)
		lrst_any |=> !latch_reg)
		else $error("latch not cleared by its reset input");
	a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		latch_reg && !lrst_any |=> latch_reg)
		else $error("latch dropped without a reset input");
	a_xor_parity: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_reg.gate == CLG_XOR
		|-> cond == ($countones(grp_a & clg_mask(na)) % 2 == 1))
		else $error("exclusive-or does not follow input parity");
	a_edge_start: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_reg.gate == CLG_EDGE && hit && !pulse_reg |=> pulse_reg)
		else $error("selected edge did not start a pulse");
	a_edge_len: assert property (@(posedge clk_i) disable iff (rst_i)
		pulse_reg && pls_reg < 23'(PULSE_CYCLES - 1) |=> pulse_reg)
		else $error("edge pulse ended early");

endmodule

// [include/clg_defines.svh]
// register map, reset values, field positions and timing counts
`ifndef CLG_DEFINES_SVH
`define CLG_DEFINES_SVH

// ****************************************
// register byte addresses
// ****************************************
`define CLG_ADR_CTRL 8'h00
`define CLG_ADR_COUNTS 8'h04
`define CLG_ADR_ON_MS 8'h08
`define CLG_ADR_OFF_MS 8'h0c
`define CLG_ADR_SETTING 8'h10
`define CLG_ADR_STATUS 8'h14

// ****************************************
// reset values
// ****************************************
`define CLG_RST_CTRL 8'h00
`define CLG_RST_COUNTS 16'h0000
`define CLG_RST_ON_MS 16'h0000
`define CLG_RST_OFF_MS 16'h0000
`define CLG_RST_SETTING 16'h0001

// ****************************************
// field positions
// ****************************************
`define CLG_CNT_A_LSB 0
`define CLG_CNT_B_LSB 4
`define CLG_CNT_C_LSB 8
`define CLG_CNT_D_LSB 12
`define CLG_ST_OUT 0
`define CLG_ST_COND 1
`define CLG_ST_LATCH 2
`define CLG_ST_PULSE 3
`define CLG_ST_DLY 4
`define CLG_ST_CNT_LSB 16

// ****************************************
// timing
// ****************************************
`define CLG_CLK_MHZ 250
`define CLG_TICK_US 1000
`define CLG_MS_CYCLES (`CLG_CLK_MHZ * `CLG_TICK_US)
`define CLG_PULSE_MS 20

`endif

// [include/clg_pkg.sv]
// types shared by the configurable logic element
package clg_pkg;

	// ****************************************
	// gate types and carriers
	// ****************************************
	typedef enum logic [3:0] {
		CLG_AND,
		CLG_OR,
		CLG_XOR,
		CLG_INV_IN_AND,
		CLG_INV_IN_OR,
		CLG_AND_OR,
		CLG_COUNTER,
		CLG_LATCH,
		CLG_EDGE
	} clg_gate_t;

	typedef struct packed {
		logic neg_pulse;
		logic edge_fall;
		logic reverse;
		logic invert;
		clg_gate_t gate;
	} clg_ctrl_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} clg_wb_req_t;

endpackage

// [testbench/clg_logic_element_tb.sv]
// self-checking bench for the configurable logic element
`include "clg_defines.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
	n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end

module clg_logic_element_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import clg_pkg::*;

	// ****************************************
	// clock, ports and bookkeeping
	// ****************************************
	localparam int MS = 10;
	localparam int PW = 20 * MS;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	clg_wb_req_t wb_i = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [15:0] sig_i = 16'h0000;
	logic sig_o;
	int n_mismatch = 0;
	int check_count = 0;
	int run = 0;
	bit strict = 1'b0;
	logic prev_o = 1'b0;
	logic [31:0] e_v, m_v;
	logic [31:0] rq_e[$];
	logic [31:0] rq_m[$];
	int tq[$];
	int t_e;

	// short ms tick keeps the delay tests to a few hundred cycles
	always #2 clk_i = ~clk_i;

	clg_logic_element #(.MS_CYCLES(MS), .PULSE_CYCLES(PW)) u_clg_logic_element (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_i(wb_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.sig_i(sig_i),
		.sig_o(sig_o)
	);

	// each result is judged against the oldest note when it appears
	always @(posedge clk_i) begin
		run = run + 1;
		if (wb_ack_o === 1'b1) begin
			e_v = rq_e.pop_front();
			m_v = rq_m.pop_front();
			`CHK("read data", e_v, wb_dat_o & m_v)
		end
		if (sig_o !== prev_o) begin
			// pop once: the check macro names its expected value twice
			if (tq.size() > 0) begin
				t_e = tq.pop_front();
				`CHK("sig_o time", t_e, run)
			end else if (strict) begin
				`CHK("sig_o change", prev_o, sig_o)
			end
			prev_o = sig_o;
		end
	end

	// ****************************************
	// bus and stimulus tasks
	// ****************************************
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		// waits for ack however long; only the watchdog ends a hang
		wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_i <= '0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rq_e.push_back(32'h0);
		rq_m.push_back(32'h0);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		rq_e.push_back(e & m);
		rq_m.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask

	// run restarts at the edge that launches the new inputs
	task automatic drive(input logic [15:0] v);
		sig_i <= v;
		run <= 0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// reference condition of the plain gates, groups of 1..8 inputs
	function automatic logic gate_cond(input int g, input logic [15:0] s,
		input int na, input int nb, input logic rev);
		logic [7:0] ma, mb, a, b, nbv;
		ma = 8'hff >> (8 - na);
		mb = 8'hff >> (8 - nb);
		a = s[7:0] & ma;
		b = s[15:8] & mb;
		nbv = ~s[15:8] & mb;
		case (g)
			0: return a == ma;
			1: return |a;
			2: return ^a;
			3: return (a == ma) && (nbv == mb);
			4: return (|a) || (|nbv);
			default: return rev ? ((|a) && (b == mb)) : ((a == ma) || (|b));
		endcase
	endfunction

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int g, na, nb;
		logic inv, rev, c;
		logic [15:0] s;
		logic [15:0] lv[7];
		logic [6:0] lo;
		lv = '{16'h0001, 16'h0000, 16'h1001, 16'h0000, 16'h0110, 16'h0000,
			16'h1110};
		lo = 7'b0110011;
		void'($urandom(32'hfc9b5000));
		idle(4);
		rst_i <= 1'b0;
		idle(1);
		rd(`CLG_ADR_CTRL, 32'h0, '1);
		rd(`CLG_ADR_COUNTS, 32'h0, '1);
		rd(`CLG_ADR_ON_MS, 32'h0, '1);
		rd(`CLG_ADR_OFF_MS, 32'h0, '1);
		rd(`CLG_ADR_SETTING, 32'h1, '1);
		wr(8'h18, 32'hffff_ffff);
		rd(8'h18, 32'h0, '1);
		// an illegal gate code keeps the condition low; invert still acts
		wr(`CLG_ADR_CTRL, 32'h5b);
		rd(`CLG_ADR_CTRL, 32'h5b, '1);
		drive(16'hffff);
		idle(3);
		rd(`CLG_ADR_STATUS, 32'h1, 32'h3);
		$display("test registers done");
		for (int i = 0; i < 48; i++) begin
			g = i % 6;
			na = $urandom_range(8, 1);
			nb = $urandom_range(8, 1);
			inv = $urandom_range(1, 0);
			rev = $urandom_range(1, 0);
			s = 16'($urandom());
			wr(`CLG_ADR_COUNTS, {24'h0, 4'(nb), 4'(na)});
			wr(`CLG_ADR_CTRL, {26'h0, rev, inv, 4'(g)});
			drive(s);
			idle(3);
			c = gate_cond(g, s, na, nb, rev);
			rd(`CLG_ADR_STATUS, {30'h0, c, c ^ inv}, 32'h3);
		end
		$display("test gates done");
		drive(16'h0000);
		wr(`CLG_ADR_COUNTS, 32'h1);
		wr(`CLG_ADR_CTRL, 32'h0);
		wr(`CLG_ADR_ON_MS, 32'h2);
		wr(`CLG_ADR_OFF_MS, 32'h1);
		idle(5);
		strict = 1'b1;
		tq.push_back(2 * MS + 3);
		drive(16'h0001);
		idle(30);
		tq.push_back(MS + 3);
		drive(16'h0000);
		idle(20);
		drive(16'h0001);
		idle(15);
		drive(16'h0000);
		idle(30);
		tq.push_back(2 * MS + 3);
		drive(16'h0001);
		idle(30);
		drive(16'h0000);
		idle(8);
		drive(16'h0001);
		idle(20);
		tq.push_back(MS + 3);
		drive(16'h0000);
		idle(20);
		strict = 1'b0;
		$display("test delays done");
		wr(`CLG_ADR_ON_MS, 32'h0);
		wr(`CLG_ADR_OFF_MS, 32'h0);
		wr(`CLG_ADR_COUNTS, 32'h1111);
		wr(`CLG_ADR_CTRL, 32'h7);
		for (int i = 0; i < 7; i++) begin
			drive(lv[i]);
			idle(4);
			rd(`CLG_ADR_STATUS, {29'h0, lo[i], 1'b0, lo[i]}, 32'h5);
		end
		$display("test latch done");
		drive(16'h0000);
		wr(`CLG_ADR_COUNTS, 32'h11);
		wr(`CLG_ADR_SETTING, 32'h3);
		wr(`CLG_ADR_CTRL, 32'h6);
		for (int k = 1; k < 5; k++) begin
			drive(16'h0001);
			idle(2);
			drive(16'h0000);
			idle(3);
			rd(`CLG_ADR_STATUS, {16'(k), 14'h0, k >= 3, 1'b0}, 32'hffff0002);
		end
		drive(16'h0100);
		idle(3);
		rd(`CLG_ADR_STATUS, 32'h0, 32'hffff0002);
		drive(16'h0000);
		$display("test counter done");
		wr(`CLG_ADR_COUNTS, 32'h1);
		wr(`CLG_ADR_CTRL, 32'h8);
		idle(5);
		strict = 1'b1;
		tq.push_back(3);
		tq.push_back(3 + PW);
		drive(16'h0001);
		idle(PW + 20);
		drive(16'h0000);
		idle(30);
		strict = 1'b0;
		wr(`CLG_ADR_CTRL, 32'hc8);
		idle(5);
		strict = 1'b1;
		drive(16'h0001);
		idle(20);
		tq.push_back(3);
		tq.push_back(3 + PW);
		drive(16'h0000);
		idle(PW + 20);
		strict = 1'b0;
		$display("test edge done");
		test_done();
	end

	// watchdog well beyond the roughly 1400 cycles the tests need
	initial begin
		#100000;
		n_mismatch++;
		test_done();
	end
endmodule
